// >>> rtl/flash_seq_pkg.sv
package flash_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_ALGO_READY_US = 11;
  localparam int unsigned RST_IDLE_READY_NS = 500;
  localparam int unsigned RST_STANDBY_US = 20;
  localparam int unsigned BUSY_DELAY_NS = 90;
  localparam int unsigned PROG_TIME_US = 18;
  localparam int unsigned ERASE_TIME_MS = 1000;
  localparam int unsigned RST_ALGO_CYC = RST_ALGO_READY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RST_IDLE_CYC = RST_IDLE_READY_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_STANDBY_CYC = RST_STANDBY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUSY_DELAY_CYC = BUSY_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC = ERASE_TIME_MS * 100000;
  localparam int unsigned CNT_W = 27;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PROTECT = 8'h68;
  localparam logic [7:0] CMD_UNPROTECT = 8'h60;
  localparam logic [7:0] CMD_PROTECT_VFY = 8'h48;
  localparam logic [7:0] CMD_UNPROTECT_VFY = 8'h40;
  localparam logic [7:0] PROT_ADDR_LOW = 8'h3A;
  localparam int unsigned SECTOR_LSB = 14;
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned OP_TOGGLE_BIT = 6;
  localparam int unsigned SUSP_TOGGLE_BIT = 2;
  localparam int unsigned PROTECT_BIT = 0;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PROGRAM = 6'h02,
    ST_ERASE = 6'h04,
    ST_SUSPENDED = 6'h08,
    ST_RESET = 6'h10,
    ST_STANDBY = 6'h20
  } state_t;
endpackage

// >>> rtl/strobe_sync.sv
`timescale 1ns/1ps
module strobe_sync (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic async_i,
  output logic sync_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (clk_en_i) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign sync_o = sync_q;
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule

// >>> rtl/flash_reset_program_status.sv
`timescale 1ns/1ps
// Overview of operation
// - Reset during algorithm aborts, ready within 11us.
// - Reset while idle gives ready within 500ns.
// - Reset low 20us enters standby.
// - Busy asserts within 90ns of write.
// - Program takes 18us, busy throughout.
// - Sector erase takes 1s, busy except while suspended.
// - Suspend toggle only inside suspended sector.
// - Toggle bits flip on chip select or output strobe.
// - Toggling stops when algorithm completes.
// - Timing select 0: ready with data.
// - Timing select 1: ready one cycle early.
// - Protect 68h, unprotect 60h.
// - Protect verify 48h, unprotect verify 40h.
// - Same cycle counts in both write modes.
// - After F0h one array read, then bursts.
module flash_reset_program_status (
  // Clock, reset and enable.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Flash pins.
  input wire logic chip_sel_n_i,
  input wire logic out_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic hw_reset_n_i,
  input wire logic write_protect_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [31:0] data_i,
  // Configuration and array side.
  input wire logic ready_timing_select_i,
  input wire logic burst_enable_i,
  input wire logic [31:0] array_rdata_i,
  // Outputs.
  output logic [31:0] data_o,
  output logic data_oe_o,
  output logic ready_busy_out_n_o,
  output logic burst_ready_o,
  output logic standby_o,
  output logic burst_mode_o,
  output logic [7:0] protect_cmd_o,
  output logic protect_cmd_valid_o
);
  logic cs_n, oe_n, we_n, rst_n;
  logic cs_rise, we_rise, oe_fall, cs_fall;

  strobe_sync u_cs (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .async_i(chip_sel_n_i), .sync_o(cs_n), .rise_o(cs_rise), .fall_o(cs_fall));
  strobe_sync u_oe (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .async_i(out_strobe_n_i), .sync_o(oe_n), .rise_o(), .fall_o(oe_fall));
  strobe_sync u_we (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .async_i(write_strobe_n_i), .sync_o(we_n), .rise_o(we_rise), .fall_o());
  strobe_sync u_rst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .async_i(hw_reset_n_i), .sync_o(rst_n), .rise_o(), .fall_o());

  // Address, data and write-protect pins pass two flops like the strobes.
  logic [19:0] addr_s1_q, addr_q;
  logic [31:0] wdata_s1_q, wdata_q;
  logic wp_s1_q, wp_n_q;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      addr_s1_q <= 20'h00000;
      addr_q <= 20'h00000;
      wdata_s1_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wp_s1_q <= 1'b1;
      wp_n_q <= 1'b1;
    end else if (clk_en_i) begin
      addr_s1_q <= addr_i;
      addr_q <= addr_s1_q;
      wdata_s1_q <= data_i;
      wdata_q <= wdata_s1_q;
      wp_s1_q <= write_protect_n_i;
      wp_n_q <= wp_s1_q;
    end
  end

  // Write completes on the earlier rising strobe of chip select or write strobe.
  logic wr_evt, rd_evt;
  assign wr_evt = (we_rise & ~cs_n) | (cs_rise & ~we_n);
  assign rd_evt = (oe_fall & ~cs_n) | (cs_fall & ~oe_n);

  flash_seq_pkg::state_t st_q, st_d;
  flash_seq_pkg::state_t resume_q, resume_d;
  logic [flash_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [flash_seq_pkg::CNT_W-1:0] rcnt_q, rcnt_d;
  logic [2:0] cyc_q, cyc_d;
  logic [5:0] sus_sector_q, sus_sector_d;
  logic [5:0] op_sector_q, op_sector_d;
  logic tog6_q, tog6_d;
  logic tog2_q, tog2_d;
  logic poll_q, poll_d;
  logic single_q, single_d;
  logic rst_busy_q, rst_busy_d;
  logic [7:0] cmd;
  logic algo;

  assign cmd = wdata_q[7:0];
  assign algo = (st_q == flash_seq_pkg::ST_PROGRAM) || (st_q == flash_seq_pkg::ST_ERASE);

  always_comb begin
    st_d = st_q;
    resume_d = resume_q;
    cnt_d = cnt_q;
    rcnt_d = rcnt_q;
    cyc_d = cyc_q;
    sus_sector_d = sus_sector_q;
    op_sector_d = op_sector_q;
    tog6_d = tog6_q;
    tog2_d = tog2_q;
    poll_d = poll_q;
    single_d = single_q;
    rst_busy_d = rst_busy_q;
    if (!rst_n) begin
      rcnt_d = rcnt_q + 1'b1;
      cyc_d = 3'h0;
      if (rcnt_q == flash_seq_pkg::CNT_W'(flash_seq_pkg::RST_STANDBY_CYC)) begin
        st_d = flash_seq_pkg::ST_STANDBY;
      end else if (st_q != flash_seq_pkg::ST_STANDBY) begin
        if (algo) begin
          st_d = flash_seq_pkg::ST_RESET;
          cnt_d = flash_seq_pkg::CNT_W'(flash_seq_pkg::RST_ALGO_CYC - 4);
          rst_busy_d = 1'b1;
        end else if (st_q != flash_seq_pkg::ST_RESET) begin
          st_d = flash_seq_pkg::ST_RESET;
          cnt_d = flash_seq_pkg::CNT_W'(flash_seq_pkg::RST_IDLE_CYC - 2);
          rst_busy_d = 1'b0;
        end else if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          rst_busy_d = 1'b0;
        end
      end
    end else begin
      rcnt_d = '0;
      case (st_q)
        flash_seq_pkg::ST_RESET, flash_seq_pkg::ST_STANDBY: begin
          st_d = flash_seq_pkg::ST_IDLE;
          rst_busy_d = 1'b0;
          single_d = 1'b1;
        end
        flash_seq_pkg::ST_PROGRAM, flash_seq_pkg::ST_ERASE: begin
          if (cnt_q == '0) begin
            st_d = flash_seq_pkg::ST_IDLE;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
          if (wr_evt && cmd == flash_seq_pkg::CMD_SUSPEND && st_q == flash_seq_pkg::ST_ERASE) begin
            st_d = flash_seq_pkg::ST_SUSPENDED;
            resume_d = st_q;
            sus_sector_d = op_sector_q;
          end
        end
        flash_seq_pkg::ST_SUSPENDED: begin
          if (wr_evt && cmd == flash_seq_pkg::CMD_RESUME) begin
            st_d = resume_q;
          end
        end
        flash_seq_pkg::ST_IDLE: begin
          if (wr_evt) begin
            cyc_d = 3'h0;
            if (cmd == flash_seq_pkg::CMD_RESET) begin
              single_d = 1'b1;
            end else if (cyc_q == 3'h0 && cmd == flash_seq_pkg::CMD_UNLOCK1) begin
              cyc_d = 3'h1;
            end else if (cyc_q == 3'h1 && cmd == flash_seq_pkg::CMD_UNLOCK2) begin
              cyc_d = 3'h2;
            end else if (cyc_q == 3'h2 && cmd == flash_seq_pkg::CMD_PROGRAM) begin
              cyc_d = 3'h3;
            end else if (cyc_q == 3'h2 && cmd == flash_seq_pkg::CMD_ERASE_SETUP) begin
              cyc_d = 3'h4;
            end else if (cyc_q == 3'h4 && cmd == flash_seq_pkg::CMD_UNLOCK1) begin
              cyc_d = 3'h5;
            end else if (cyc_q == 3'h5 && cmd == flash_seq_pkg::CMD_UNLOCK2) begin
              cyc_d = 3'h6;
            end else if (cyc_q == 3'h3 && wp_n_q) begin
              st_d = flash_seq_pkg::ST_PROGRAM;
              cnt_d = flash_seq_pkg::CNT_W'(flash_seq_pkg::PROG_CYC - 1);
              poll_d = ~wdata_q[flash_seq_pkg::POLL_BIT];
              op_sector_d = addr_q[19:flash_seq_pkg::SECTOR_LSB];
            end else if (cyc_q == 3'h6 && cmd == flash_seq_pkg::CMD_SECTOR_ERASE && wp_n_q) begin
              st_d = flash_seq_pkg::ST_ERASE;
              cnt_d = flash_seq_pkg::CNT_W'(flash_seq_pkg::ERASE_CYC - 1);
              poll_d = 1'b0;
              op_sector_d = addr_q[19:flash_seq_pkg::SECTOR_LSB];
            end
          end
        end
        default: st_d = flash_seq_pkg::ST_IDLE;
      endcase
      if (rd_evt) begin
        single_d = 1'b0;
        if (algo) begin
          tog6_d = ~tog6_q;
        end
        if (st_q == flash_seq_pkg::ST_SUSPENDED &&
            addr_q[19:flash_seq_pkg::SECTOR_LSB] == sus_sector_q) begin
          tog2_d = ~tog2_q;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q <= flash_seq_pkg::ST_IDLE;
      resume_q <= flash_seq_pkg::ST_ERASE;
      cnt_q <= '0;
      rcnt_q <= '0;
      cyc_q <= 3'h0;
      sus_sector_q <= 6'h3F;
      op_sector_q <= 6'h00;
      tog6_q <= 1'b0;
      tog2_q <= 1'b0;
      poll_q <= 1'b0;
      single_q <= 1'b1;
      rst_busy_q <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      resume_q <= resume_d;
      cnt_q <= cnt_d;
      rcnt_q <= rcnt_d;
      cyc_q <= cyc_d;
      sus_sector_q <= sus_sector_d;
      op_sector_q <= op_sector_d;
      tog6_q <= tog6_d;
      tog2_q <= tog2_d;
      poll_q <= poll_d;
      single_q <= single_d;
      rst_busy_q <= rst_busy_d;
    end
  end

  // Output stage: every pin comes from a flop.
  logic [31:0] dout_d;
  logic vld_d, vld_q, busy_d;

  always_comb begin
    dout_d = array_rdata_i;
    if (algo) begin
      dout_d = 32'h00000000;
      dout_d[flash_seq_pkg::POLL_BIT] = poll_q;
      dout_d[flash_seq_pkg::OP_TOGGLE_BIT] = tog6_q;
      dout_d[flash_seq_pkg::SUSP_TOGGLE_BIT] = tog2_q;
    end else if (st_q == flash_seq_pkg::ST_SUSPENDED &&
                 addr_q[19:flash_seq_pkg::SECTOR_LSB] == sus_sector_q) begin
      dout_d = 32'h00000000;
      dout_d[flash_seq_pkg::POLL_BIT] = 1'b1;
      dout_d[flash_seq_pkg::SUSP_TOGGLE_BIT] = tog2_q;
    end
    vld_d = ~cs_n & ~oe_n & rst_n;
    busy_d = (st_d == flash_seq_pkg::ST_PROGRAM) || (st_d == flash_seq_pkg::ST_ERASE) ||
             (st_d == flash_seq_pkg::ST_RESET && rst_busy_d);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      data_o <= 32'h00000000;
      data_oe_o <= 1'b0;
      vld_q <= 1'b0;
      ready_busy_out_n_o <= 1'b1;
      burst_ready_o <= 1'b0;
      standby_o <= 1'b0;
      burst_mode_o <= 1'b0;
      protect_cmd_o <= 8'h00;
      protect_cmd_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      data_o <= dout_d;
      data_oe_o <= vld_q;
      vld_q <= vld_d;
      ready_busy_out_n_o <= ~busy_d;
      burst_ready_o <= ready_timing_select_i ? vld_d : vld_q;
      standby_o <= (st_d == flash_seq_pkg::ST_STANDBY);
      burst_mode_o <= burst_enable_i & ~single_d;
      protect_cmd_valid_o <= 1'b0;
      if (wr_evt && st_q == flash_seq_pkg::ST_IDLE && rst_n &&
          addr_q[7:0] == flash_seq_pkg::PROT_ADDR_LOW &&
          (cmd == flash_seq_pkg::CMD_PROTECT || cmd == flash_seq_pkg::CMD_UNPROTECT ||
           cmd == flash_seq_pkg::CMD_PROTECT_VFY ||
           cmd == flash_seq_pkg::CMD_UNPROTECT_VFY)) begin
        protect_cmd_o <= cmd;
        protect_cmd_valid_o <= 1'b1;
      end
    end
  end
endmodule

// >>> dv/flash_seq_checker.sv
`timescale 1ns/1ps
module flash_seq_checker (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Watched pins.
  input wire logic chip_sel_n_i,
  input wire logic write_strobe_n_i,
  input wire logic hw_reset_n_i,
  input wire logic data_oe_o,
  input wire logic ready_busy_out_n_o,
  input wire logic standby_o,
  input wire logic [7:0] protect_cmd_o,
  input wire logic protect_cmd_valid_o
);
  logic cs_q;
  logic we_q;
  logic [9:0] wr_age_q;
  logic [11:0] low_cnt_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles since the last write edge, and cycles the reset pin has been low.
  always_ff @(posedge mclk_i) begin
    cs_q <= chip_sel_n_i;
    we_q <= write_strobe_n_i;
    if (sys_rst_i) begin
      wr_age_q <= 10'h3FF;
    end else if ((chip_sel_n_i && !cs_q) || (write_strobe_n_i && !we_q)) begin
      wr_age_q <= 10'h000;
    end else if (wr_age_q != 10'h3FF) begin
      wr_age_q <= wr_age_q + 10'h001;
    end
    if (sys_rst_i || hw_reset_n_i) begin
      low_cnt_q <= 12'h000;
    end else if (low_cnt_q != 12'hFFF) begin
      low_cnt_q <= low_cnt_q + 12'h001;
    end
  end
  a_busy_after_write: assert property (
    $fell(ready_busy_out_n_o) && hw_reset_n_i |-> wr_age_q <= 10'd9)
    else $error("busy fell too late after a write edge");
  a_ready_after_reset: assert property (
    low_cnt_q >= 12'd1100 |-> ready_busy_out_n_o)
    else $error("not ready while reset pin held low");
  a_standby_late: assert property (
    $rose(standby_o) |-> low_cnt_q >= 12'd1998)
    else $error("standby entered too early");
  a_standby_on: assert property (
    low_cnt_q >= 12'd2010 |-> standby_o)
    else $error("standby not entered");
  a_standby_off: assert property (
    hw_reset_n_i [*6] |-> !standby_o)
    else $error("standby while reset pin high");
  a_oe_idle: assert property (
    chip_sel_n_i [*5] |-> !data_oe_o)
    else $error("output enabled without chip select");
  a_prot_code: assert property (
    protect_cmd_valid_o |-> protect_cmd_o inside {8'h68, 8'h60, 8'h48, 8'h40})
    else $error("bad protect code");
  a_prot_pulse: assert property (
    protect_cmd_valid_o |=> !protect_cmd_valid_o)
    else $error("protect pulse too long");
endmodule
bind flash_reset_program_status flash_seq_checker u_chk (.mclk_i, .sys_rst_i, .chip_sel_n_i,
  .write_strobe_n_i, .hw_reset_n_i, .data_oe_o, .ready_busy_out_n_o, .standby_o,
  .protect_cmd_o, .protect_cmd_valid_o);

// >>> dv/flash_host.sv
`timescale 1ns/1ps
module flash_host (
  // Clock and read data.
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  // Pins toward the device.
  output logic chip_sel_n_o = 1'b1,
  output logic out_strobe_n_o = 1'b1,
  output logic write_strobe_n_o = 1'b1,
  output logic hw_reset_n_o = 1'b1,
  output logic write_protect_n_o = 1'b1,
  output logic [19:0] addr_o = 20'h00000,
  output logic [31:0] data_o = 32'h00000000
);
  // One bus write; cs_ctl selects which strobe falls last and rises first.
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic cs_ctl);
    @(posedge mclk_i);
    addr_o <= a;
    data_o <= d;
    if (cs_ctl) write_strobe_n_o <= 1'b0; else chip_sel_n_o <= 1'b0;
    @(posedge mclk_i);
    if (cs_ctl) chip_sel_n_o <= 1'b0; else write_strobe_n_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    if (cs_ctl) chip_sel_n_o <= 1'b1; else write_strobe_n_o <= 1'b1;
    @(posedge mclk_i);
    chip_sel_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    data_o <= ~d;
    repeat (4) @(posedge mclk_i);
  endtask
  // One read strobed by chip select or by output strobe.
  task automatic rd(input logic [19:0] a, input logic cs_ctl, output logic [31:0] q);
    @(posedge mclk_i);
    addr_o <= a;
    if (cs_ctl) out_strobe_n_o <= 1'b0; else chip_sel_n_o <= 1'b0;
    @(posedge mclk_i);
    if (cs_ctl) chip_sel_n_o <= 1'b0; else out_strobe_n_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    q = rdata_i;
    chip_sel_n_o <= 1'b1;
    out_strobe_n_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic set_reset(input logic v);
    @(posedge mclk_i);
    hw_reset_n_o <= v;
  endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic ready_timing_select_i = 1'b0;
  logic burst_enable_i = 1'b0;
  logic [31:0] array_rdata_i = 32'hA5A5F0F0;
  logic chip_sel_n_i, out_strobe_n_i, write_strobe_n_i, hw_reset_n_i, write_protect_n_i;
  logic [19:0] addr_i;
  logic [31:0] data_i, data_o, r0, r1;
  logic data_oe_o, ready_busy_out_n_o, burst_ready_o, standby_o, burst_mode_o;
  logic protect_cmd_valid_o;
  logic [7:0] protect_cmd_o, prot_q;
  int num_errors = 0;
  int samples_checked = 0;
  int prot_cnt = 0;
  int early_cnt = 0;
  int both_cnt = 0;
  int n;
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (protect_cmd_valid_o === 1'b1) begin
      prot_q <= protect_cmd_o;
      prot_cnt <= prot_cnt + 1;
    end
    if (burst_ready_o === 1'b1 && data_oe_o !== 1'b1) early_cnt <= early_cnt + 1;
    if (burst_ready_o === 1'b1 && data_oe_o === 1'b1) both_cnt <= both_cnt + 1;
  end
  flash_host u_host (.mclk_i, .rdata_i(data_o), .chip_sel_n_o(chip_sel_n_i),
    .out_strobe_n_o(out_strobe_n_i), .write_strobe_n_o(write_strobe_n_i),
    .hw_reset_n_o(hw_reset_n_i), .write_protect_n_o(write_protect_n_i),
    .addr_o(addr_i), .data_o(data_i));
  flash_reset_program_status u_dut (.mclk_i, .sys_rst_i, .clk_en_i, .chip_sel_n_i,
    .out_strobe_n_i, .write_strobe_n_i, .hw_reset_n_i, .write_protect_n_i, .addr_i,
    .data_i, .ready_timing_select_i, .burst_enable_i, .array_rdata_i, .data_o, .data_oe_o,
    .ready_busy_out_n_o, .burst_ready_o, .standby_o, .burst_mode_o, .protect_cmd_o,
    .protect_cmd_valid_o);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_ready(input int lim);
    n = 0;
    while (ready_busy_out_n_o !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    if (ready_busy_out_n_o !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic rd2(input logic [19:0] a, input logic cs_ctl);
    u_host.rd(a, cs_ctl, r0);
    u_host.rd(a, cs_ctl, r1);
  endtask
  function automatic logic [31:0] flip(input int b);
    return {31'h0, r0[b] ^ r1[b]};
  endfunction
  task automatic t_program(input logic cs_ctl);
    u_host.wr(20'h05555, 32'h000000AA, cs_ctl);
    u_host.wr(20'h02AAA, 32'h00000055, cs_ctl);
    u_host.wr(20'h05555, 32'h000000A0, cs_ctl);
    u_host.wr(20'h00100, 32'h12345678, cs_ctl);
    cmp({31'h0, ready_busy_out_n_o}, 32'h0);
    rd2(20'h00100, cs_ctl);
    cmp(flip(6), 32'h1);
    wait_ready(2000);
    cmp({31'h0, n + 100 > flash_seq_pkg::PROG_CYC && n < flash_seq_pkg::PROG_CYC}, 32'h1);
    rd2(20'h00100, cs_ctl);
    cmp(flip(6), 32'h0);
  endtask
  task automatic t_protect();
    logic [7:0] pc [4] = '{8'h68, 8'h60, 8'h48, 8'h40};
    for (int k = 0; k < 4; k++) begin
      u_host.wr(20'h0003A, {24'h0, pc[k]}, k[0]);
      cmp({24'h0, prot_q}, {24'h0, pc[k]});
    end
    n = prot_cnt;
    u_host.wr(20'h00055, 32'h00000068, 1'b0);
    cmp(32'(prot_cnt - n), 32'h0);
  endtask
  task automatic t_erase();
    logic [7:0] sq [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
    for (int k = 0; k < 6; k++) u_host.wr(k == 5 ? 20'h14000 : 20'h05555, {24'h0, sq[k]}, 1'b0);
    cmp({31'h0, ready_busy_out_n_o}, 32'h0);
    rd2(20'h14000, 1'b0);
    cmp(flip(6), 32'h1);
    u_host.wr(20'h14000, 32'h000000B0, 1'b0);
    repeat (20) @(posedge mclk_i);
    rd2(20'h14000, 1'b1);
    cmp(flip(2), 32'h1);
    rd2(20'h00000, 1'b1);
    cmp(flip(2), 32'h0);
    u_host.wr(20'h14000, 32'h00000030, 1'b0);
    rd2(20'h14000, 1'b0);
    cmp(flip(6), 32'h1);
    u_host.set_reset(1'b0);
    repeat (100) @(posedge mclk_i);
    wait_ready(1001);
    cmp({31'h0, ready_busy_out_n_o}, 32'h1);
    u_host.set_reset(1'b1);
    repeat (5) @(posedge mclk_i);
    rd2(20'h14000, 1'b0);
    cmp(flip(6), 32'h0);
  endtask
  task automatic t_burst();
    int e0;
    int b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      ready_timing_select_i <= k[0];
      e0 = early_cnt;
      b0 = both_cnt;
      u_host.rd(20'h00000, 1'b0, r0);
      cmp(32'(early_cnt - e0), 32'(k));
      cmp({31'h0, both_cnt > b0}, 32'h1);
    end
    @(posedge mclk_i);
    burst_enable_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    cmp({31'h0, burst_mode_o}, 32'h1);
    u_host.wr(20'h00000, 32'h000000F0, 1'b0);
    cmp({31'h0, burst_mode_o}, 32'h0);
    u_host.rd(20'h00000, 1'b1, r0);
    cmp({31'h0, burst_mode_o}, 32'h1);
  endtask
  task automatic t_standby();
    u_host.set_reset(1'b0);
    repeat (1900) @(posedge mclk_i);
    cmp({30'h0, standby_o, ready_busy_out_n_o}, 32'h1);
    repeat (120) @(posedge mclk_i);
    cmp({31'h0, standby_o}, 32'h1);
    u_host.set_reset(1'b1);
    repeat (60) @(posedge mclk_i);
    cmp({30'h0, standby_o, ready_busy_out_n_o}, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    t_program(1'b0);
    t_program(1'b1);
    t_protect();
    t_erase();
    t_burst();
    t_standby();
    end_sim();
  end
endmodule
